// >>> rtl/hrc_pkg.sv
// hrc_pkg: register map, field values and bus carriers of the host register controller
package hrc_pkg;
	// ----------------------------------------------------------------
	// local register offsets (7-bit register pointer space)
	// ----------------------------------------------------------------
	localparam logic [6:0] OFS_PKT0      = 7'h09;
	localparam logic [6:0] OFS_PKT3      = 7'h0c;
	localparam logic [6:0] OFS_MADDR0    = 7'h20;
	localparam logic [6:0] OFS_MADDR1    = 7'h21;
	localparam logic [6:0] OFS_MADDR3    = 7'h23;
	localparam logic [6:0] OFS_MDATA0    = 7'h28;
	localparam logic [6:0] OFS_MDATA3    = 7'h2b;
	localparam logic [6:0] OFS_AHB_STAT  = 7'h2f;
	localparam logic [6:0] OFS_ACC_CTL   = 7'h30;
	localparam logic [6:0] OFS_SCRATCH   = 7'h31;
	localparam logic [6:0] OFS_GEN_STAT  = 7'h32;
	localparam logic [6:0] OFS_DMA_DBG0  = 7'h36;
	localparam logic [6:0] OFS_DMA_DBG1  = 7'h37;
	localparam logic [6:0] OFS_DADDR0    = 7'h38;
	localparam logic [6:0] OFS_DADDR3    = 7'h3b;
	localparam logic [6:0] OFS_BLEN_LO   = 7'h3c;
	localparam logic [6:0] OFS_BLEN_HI   = 7'h3d;
	localparam logic [6:0] OFS_DMA_STAT  = 7'h3f;
	localparam logic [6:0] OFS_DMA_RD    = 7'h40;
	localparam logic [6:0] OFS_DEV_ID    = 7'h7f;
	// ----------------------------------------------------------------
	// field values and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] RD_SUPPRESS   = 2'h3;
	localparam logic [1:0] DMA_NO_KICK   = 2'h2;
	localparam logic [15:0] ADDR_STEP    = 16'h0004;
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [4:0] DFIFO_DEPTH   = 5'h10;
	localparam logic [4:0] DFIFO_ROOM    = 5'h0c;
	// ----------------------------------------------------------------
	// ahb encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_IDLE   = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
	} hrc_ahb_out_type;
	typedef struct packed {
		logic [31:0] hrdata;
		logic        hready;
		logic        hresp;
	} hrc_ahb_in_type;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ADDR = 2'h1, ST_DATA = 2'h3} hrc_state_type;
	typedef enum logic [1:0] {KIND_WR = 2'h0, KIND_RD = 2'h1, KIND_DMA = 2'h2} hrc_kind_type;
endpackage

// >>> rtl/hrc_spi_shifter.sv
// hrc_spi_shifter: mode 0 serial byte shifter sampled on the system clock
`timescale 1ns/10ps
`default_nettype none
module hrc_spi_shifter (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       sclk,
	input  wire logic       ss_n,
	input  wire logic       mosi,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_load,
	output logic      [7:0] rx_byte,
	output logic            rx_done,
	output logic            frame_start,
	output logic            tx_start,
	output logic            miso,
	output logic            miso_oe
);
	import hrc_pkg::*;
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] s1_q, s2_q, s3_q;
	logic [2:0] cnt_q;
	logic [7:0] in_q, out_q;
	logic       fresh_q;
	logic       rise, fall, active;
	// pins cross into clk here before any decode
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_q <= 3'h2;
			s2_q <= 3'h2;
			s3_q <= 3'h2;
		end
		else
		begin
			s1_q <= {sclk, ss_n, mosi};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign active = !s2_q[1];
	assign rise   = active && s2_q[2] && !s3_q[2];
	assign fall   = active && !s2_q[2] && s3_q[2];
	// ----------------------------------------------------------------
	// receive side
	// ----------------------------------------------------------------
	// an incomplete last byte is simply dropped at frame end
	always_ff @(posedge clk)
	begin
		if (!rst_n || !active)
		begin
			cnt_q   <= 3'h0;
			rx_done <= 1'b0;
			if (!rst_n)
			begin
				in_q    <= RST_BYTE;
				rx_byte <= RST_BYTE;
			end
		end
		else
		begin
			rx_done <= 1'b0;
			if (rise)
			begin
				in_q  <= {in_q[6:0], s2_q[0]};
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == 3'h7)
				begin
					rx_byte <= {in_q[6:0], s2_q[0]};
					rx_done <= 1'b1;
				end
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			frame_start <= 1'b0;
		else
			frame_start <= s3_q[1] && !s2_q[1];
	end
	// first bit of a byte: the host is now committed to the byte loaded for it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tx_start <= 1'b0;
		else
			tx_start <= rise && cnt_q == 3'h0;
	end
	// ----------------------------------------------------------------
	// transmit side
	// ----------------------------------------------------------------
	// a freshly loaded byte keeps its msb over the next falling edge
	always_ff @(posedge clk)
	begin
		if (!rst_n || (!active && !tx_load))
		begin
			out_q   <= RST_BYTE;
			fresh_q <= 1'b0;
		end
		else if (tx_load)
		begin
			out_q   <= tx_byte;
			fresh_q <= 1'b1;
		end
		else if (fall)
		begin
			if (fresh_q)
				fresh_q <= 1'b0;
			else
				out_q <= {out_q[6:0], 1'b0};
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			miso    <= 1'b0;
			miso_oe <= 1'b0;
		end
		else
		begin
			miso    <= out_q[7];
			miso_oe <= active;
		end
	end
endmodule // hrc_spi_shifter
`default_nettype wire

// >>> rtl/hrc_host_register_controller.sv
// hrc_host_register_controller: host register file, ahb word master and burst read dma
// Function
// - first byte: msb set means write, low seven bits pick the register
// - local register accesses start no ahb transfer, except writes to address byte 1, data byte 3 and high length
// - pointer advances by one after each byte, independent of memory address
// - advancing stops only at frame end or at a non-advancing register
// - register side effects still fire during streamed accesses
// - bytes written to packet fifo ports are dropped
// - pointer holds on packet fifo ports so reads pop successive entries
// - every ahb transfer is one 32-bit word
// - address byte 1 write launches word read unless both mode bits are 3
// - returned read word lands in the four memory data bytes
// - reading memory data bytes leaves memory address bytes alone
// - all writes share one path; single write is a one-word burst
// - data byte 3 write issues ahb write and adds four to address
// - after data byte 3 the pointer returns to data byte 0
// - upper address bytes never change, bursts wrap inside 64K
// - burst reads run on a dma engine filling a read fifo
// - host loads burst address and low length; high length starts dma
// - length is bytes minus four; no start if low bits are 2'b10
// - pointer holds on the burst data port so reads drain the fifo
`timescale 1ns/10ps
`default_nettype none
module hrc_host_register_controller #(
	parameter logic [7:0] DEVICE_ID = 8'h5a // arbitrary value
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    sclk,
	input  wire logic                    ss_n,
	input  wire logic                    mosi,
	output logic                         miso,
	output logic                         miso_oe,
	output hrc_pkg::hrc_ahb_out_type     ahb_o,
	input  wire hrc_pkg::hrc_ahb_in_type ahb_i,
	input  wire logic [3:0][7:0]         pkt_data,
	output logic      [3:0]              pkt_pop,
	input  wire logic [7:0]              gen_status
);
	import hrc_pkg::*;
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0]       rx_byte, tx_q, rd_byte;
	logic             rx_done, frame_start, tx_load_q;
	logic [6:0]       ptr_q;
	logic             wmode_q, wr_en, rd_en;
	logic [1:0]       cnt_q;
	logic [3:0][7:0]  maddr_q, mdata_q, daddr_q;
	logic [1:0][7:0]  blen_q;
	logic [7:0]       ctl_q, scratch_q, dbg0_q, dbg1_q;
	logic             wr_pend_q, rd_pend_q, rd_valid_q;
	logic [31:0]      wr_addr_q, wr_data_q;
	hrc_state_type    state_q;
	hrc_kind_type     kind_q;
	logic             take_wr, take_rd, take_dma, done_rd, done_dma, ahb_done;
	logic             dma_run_q, under_q, flush;
	logic [31:0]      dcur_q;
	logic [14:0]      dleft_q;
	logic [15:0][7:0] dfifo_q;
	logic [4:0]       dwp_q, drp_q, dcnt;
	logic             dempty, pop_dma, pop_pkt;
	logic             tx_start, owe_dma_q, owe_udf_q;
	logic [3:0]       owe_pkt_q;
	logic [7:0]       ahb_stat, dma_stat;
	logic             set_wr, set_rd, start_dma;
	function automatic logic is_pkt(input logic [6:0] p);
		return p >= OFS_PKT0 && p <= OFS_PKT3;
	endfunction
	function automatic logic in_rng(input logic [6:0] p, input logic [6:0] lo);
		return p[6:2] == lo[6:2];
	endfunction
	// pointer step shared by read and write streams
	function automatic logic [6:0] next_ptr(input logic [6:0] p);
		if (is_pkt(p) || p == OFS_DMA_RD)
			return p;
		else if (p == OFS_MDATA3)
			return OFS_MDATA0;
		else
			return p + 7'h01;
	endfunction
	// ----------------------------------------------------------------
	// serial byte link
	// ----------------------------------------------------------------
	hrc_spi_shifter u_shift (
		.clk         (clk),
		.rst_n       (rst_n),
		.sclk        (sclk),
		.ss_n        (ss_n),
		.mosi        (mosi),
		.tx_byte     (tx_q),
		.tx_load     (tx_load_q),
		.rx_byte     (rx_byte),
		.rx_done     (rx_done),
		.frame_start (frame_start),
		.tx_start    (tx_start),
		.miso        (miso),
		.miso_oe     (miso_oe)
	);
	// ----------------------------------------------------------------
	// frame sequencing and register pointer
	// ----------------------------------------------------------------
	assign wr_en = rx_done && cnt_q != 2'h0 && wmode_q;
	assign rd_en = rx_done && cnt_q == 2'h2 && !wmode_q;
	// two dummy byte slots give the read mux and fifos time to settle
	always_ff @(posedge clk)
	begin
		if (!rst_n || frame_start)
		begin
			cnt_q <= 2'h0;
			if (!rst_n)
			begin
				ptr_q   <= 7'h00;
				wmode_q <= 1'b0;
			end
		end
		else if (rx_done)
		begin
			if (cnt_q == 2'h0)
			begin
				ptr_q   <= rx_byte[6:0];
				wmode_q <= rx_byte[7];
				cnt_q   <= 2'h1;
			end
			else if (!wmode_q && cnt_q == 2'h1)
				cnt_q <= 2'h2;
			else
				ptr_q <= next_ptr(ptr_q);
		end
	end
	// ----------------------------------------------------------------
	// read mux, local only
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_byte = RST_BYTE;
		if (is_pkt(ptr_q))
			rd_byte = pkt_data[2'(ptr_q - OFS_PKT0)];
		else if (in_rng(ptr_q, OFS_MADDR0))
			rd_byte = maddr_q[ptr_q[1:0]];
		else if (in_rng(ptr_q, OFS_MDATA0))
			rd_byte = mdata_q[ptr_q[1:0]];
		else if (in_rng(ptr_q, OFS_DADDR0))
			rd_byte = daddr_q[ptr_q[1:0]];
		else
		begin
			case (ptr_q)
				OFS_AHB_STAT: rd_byte = ahb_stat;
				OFS_ACC_CTL:  rd_byte = ctl_q;
				OFS_SCRATCH:  rd_byte = scratch_q;
				OFS_GEN_STAT: rd_byte = gen_status;
				OFS_DMA_DBG0: rd_byte = dbg0_q;
				OFS_DMA_DBG1: rd_byte = dbg1_q;
				OFS_BLEN_LO:  rd_byte = blen_q[0];
				OFS_BLEN_HI:  rd_byte = blen_q[1];
				OFS_DMA_STAT: rd_byte = dma_stat;
				OFS_DMA_RD:   rd_byte = dempty ? RST_BYTE : dfifo_q[drp_q[3:0]];
				OFS_DEV_ID:   rd_byte = DEVICE_ID;
				default:      rd_byte = RST_BYTE;
			endcase
		end
	end
	assign pop_pkt = tx_start && owe_pkt_q != 4'h0;
	assign pop_dma = tx_start && owe_dma_q;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_q      <= RST_BYTE;
			tx_load_q <= 1'b0;
			pkt_pop   <= 4'h0;
		end
		else
		begin
			tx_load_q <= rd_en;
			pkt_pop   <= 4'h0;
			if (rd_en)
				tx_q <= rd_byte;
			if (pop_pkt)
				pkt_pop <= owe_pkt_q;
		end
	end
	// look-ahead bytes pop only once the host shifts them, so a frame end loses no entry
	always_ff @(posedge clk)
	begin
		if (!rst_n || frame_start)
		begin
			owe_pkt_q <= 4'h0;
			owe_dma_q <= 1'b0;
			owe_udf_q <= 1'b0;
		end
		else if (rd_en)
		begin
			owe_pkt_q <= 4'h0;
			if (is_pkt(ptr_q))
				owe_pkt_q[2'(ptr_q - OFS_PKT0)] <= 1'b1;
			owe_dma_q <= ptr_q == OFS_DMA_RD && !dempty;
			owe_udf_q <= ptr_q == OFS_DMA_RD && dempty;
		end
		else if (tx_start)
		begin
			owe_pkt_q <= 4'h0;
			owe_dma_q <= 1'b0;
			owe_udf_q <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// plain local registers
	// ----------------------------------------------------------------
	// packet fifo ports have no write decode, so such bytes vanish
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctl_q     <= RST_BYTE;
			scratch_q <= RST_BYTE;
			dbg0_q    <= RST_BYTE;
			dbg1_q    <= RST_BYTE;
			daddr_q   <= '0;
			blen_q    <= '0;
		end
		else if (wr_en)
		begin
			case (ptr_q)
				OFS_ACC_CTL:  ctl_q <= rx_byte;
				OFS_SCRATCH:  scratch_q <= rx_byte;
				OFS_DMA_DBG0: dbg0_q <= {7'h00, rx_byte[0]};
				OFS_DMA_DBG1: dbg1_q <= {7'h00, rx_byte[0]};
				OFS_BLEN_LO:  blen_q[0] <= rx_byte;
				OFS_BLEN_HI:  blen_q[1] <= rx_byte;
				default:
				begin
					if (in_rng(ptr_q, OFS_DADDR0))
						daddr_q[ptr_q[1:0]] <= rx_byte;
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// memory address and data bytes
	// ----------------------------------------------------------------
	assign set_rd = wr_en && ptr_q == OFS_MADDR1
		&& !(maddr_q[0][1:0] == RD_SUPPRESS && ctl_q[1:0] == RD_SUPPRESS);
	assign set_wr = wr_en && ptr_q == OFS_MDATA3;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			maddr_q <= '0;
		else if (wr_en && in_rng(ptr_q, OFS_MADDR0))
			maddr_q[ptr_q[1:0]] <= rx_byte;
		else if (set_wr)
			maddr_q[1:0] <= maddr_q[1:0] + ADDR_STEP;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mdata_q <= '0;
		else if (wr_en && in_rng(ptr_q, OFS_MDATA0))
			mdata_q[ptr_q[1:0]] <= rx_byte;
		else if (done_rd)
			mdata_q <= ahb_i.hrdata;
	end
	// the word is captured whole, so later data bytes cannot tear it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_addr_q <= 32'h0;
			wr_data_q <= 32'h0;
		end
		else if (set_wr)
		begin
			wr_addr_q <= {maddr_q[3:1], maddr_q[0][7:2], 2'h0};
			wr_data_q <= {rx_byte, mdata_q[2], mdata_q[1], mdata_q[0]};
		end
	end
	// set after take, so a new launch is never lost
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_pend_q  <= 1'b0;
			rd_pend_q  <= 1'b0;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			if (take_wr)
				wr_pend_q <= 1'b0;
			if (set_wr)
				wr_pend_q <= 1'b1;
			if (take_rd)
				rd_pend_q <= 1'b0;
			if (done_rd)
				rd_valid_q <= 1'b1;
			if (set_rd)
			begin
				rd_pend_q  <= 1'b1;
				rd_valid_q <= 1'b0;
			end
		end
	end
	assign ahb_stat = {2'h0, 2'h0, !(wr_pend_q || rd_pend_q), wr_pend_q && rd_pend_q, rd_valid_q,
		wr_pend_q || rd_pend_q || (state_q != ST_IDLE && kind_q != KIND_DMA)};
	// ----------------------------------------------------------------
	// ahb word master
	// ----------------------------------------------------------------
	assign take_wr  = state_q == ST_IDLE && wr_pend_q;
	assign take_rd  = state_q == ST_IDLE && !wr_pend_q && rd_pend_q;
	assign take_dma = state_q == ST_IDLE && !wr_pend_q && !rd_pend_q && dma_run_q
		&& dleft_q != 15'h0 && dcnt <= DFIFO_ROOM && !dbg1_q[0];
	assign ahb_done = state_q == ST_DATA && ahb_i.hready;
	assign done_rd  = ahb_done && kind_q == KIND_RD;
	assign done_dma = ahb_done && kind_q == KIND_DMA;
	// error responses end the transfer like an okay; data is then undefined
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			kind_q  <= KIND_WR;
			ahb_o   <= '{haddr: 32'h0, htrans: HTRANS_IDLE, hwrite: 1'b0, hsize: HSIZE_WORD, hwdata: 32'h0};
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (take_wr || take_rd || take_dma)
					begin
						state_q      <= ST_ADDR;
						ahb_o.htrans <= HTRANS_NONSEQ;
						ahb_o.hsize  <= HSIZE_WORD;
						ahb_o.hwrite <= take_wr;
						if (take_wr)
						begin
							kind_q      <= KIND_WR;
							ahb_o.haddr <= wr_addr_q;
						end
						else if (take_rd)
						begin
							kind_q      <= KIND_RD;
							ahb_o.haddr <= {maddr_q[3:1], maddr_q[0][7:2], 2'h0};
						end
						else
						begin
							kind_q      <= KIND_DMA;
							ahb_o.haddr <= dcur_q;
						end
					end
				end
				ST_ADDR:
				begin
					if (ahb_i.hready)
					begin
						state_q      <= ST_DATA;
						ahb_o.htrans <= HTRANS_IDLE;
						if (kind_q == KIND_WR)
							ahb_o.hwdata <= wr_data_q;
					end
				end
				ST_DATA:
				begin
					if (ahb_i.hready)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// burst read dma engine
	// ----------------------------------------------------------------
	assign start_dma = wr_en && ptr_q == OFS_BLEN_HI && blen_q[0][1:0] != DMA_NO_KICK;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dma_run_q <= 1'b0;
			dcur_q    <= 32'h0;
			dleft_q   <= 15'h0;
		end
		else if (dbg1_q[0])
			dma_run_q <= 1'b0;
		else if (start_dma)
		begin
			dma_run_q <= 1'b1;
			dcur_q    <= {daddr_q[3:1], daddr_q[0][7:2], 2'h0};
			dleft_q   <= {1'b0, rx_byte, blen_q[0][7:2]} + 15'h0001;
		end
		else if (done_dma)
		begin
			dcur_q  <= dcur_q + 32'h4;
			dleft_q <= dleft_q - 15'h0001;
			if (dleft_q == 15'h0001)
				dma_run_q <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// dma byte fifo
	// ----------------------------------------------------------------
	assign dcnt   = dwp_q - drp_q;
	assign dempty = dcnt == 5'h0;
	assign flush  = dbg0_q[0] || dbg1_q[0];
	always_ff @(posedge clk)
	begin
		if (!rst_n || flush)
		begin
			dwp_q <= 5'h0;
			drp_q <= 5'h0;
		end
		else
		begin
			if (done_dma)
				dwp_q <= dwp_q + 5'h4;
			if (pop_dma && !dempty)
				drp_q <= drp_q + 5'h1;
		end
	end
	// word enters lsb first, matching the memory data byte order
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			dfifo_q <= '0;
		else if (done_dma)
		begin
			for (int i = 0; i < 4; i++)
				dfifo_q[4'(dwp_q[3:0] + 4'(i))] <= ahb_i.hrdata[8*i +: 8];
		end
	end
	// underflow set wins over the clear of a new start
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			under_q <= 1'b0;
		else if (tx_start && owe_udf_q)
			under_q <= 1'b1;
		else if (start_dma)
			under_q <= 1'b0;
	end
	assign dma_stat = {6'h00, under_q, dempty};
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_word_size_only: assert property (ahb_o.htrans == HTRANS_NONSEQ |-> ahb_o.hsize == HSIZE_WORD)
		else $error("ahb transfer not a word");
	a_local_no_ahb: assert property (wr_en && ptr_q == OFS_SCRATCH && state_q == ST_IDLE
		&& !wr_pend_q && !rd_pend_q && !dma_run_q |=> ahb_o.htrans == HTRANS_IDLE)
		else $error("local write started ahb");
	a_ptr_step_one: assert property (wr_en && ptr_q == OFS_SCRATCH |=> ptr_q == OFS_GEN_STAT)
		else $error("pointer did not advance");
	a_pkt_ptr_hold: assert property (rd_en && is_pkt(ptr_q) |=> $stable(ptr_q) && owe_pkt_q != 4'h0)
		else $error("packet port pointer moved");
	a_pop_on_shift: assert property (pop_pkt |=> pkt_pop == $past(owe_pkt_q))
		else $error("packet pop not issued");
	a_pkt_wr_drop: assert property (wr_en && is_pkt(ptr_q) |=> pkt_pop == 4'h0 && $stable(ctl_q))
		else $error("packet port write had effect");
	a_dma_ptr_hold: assert property (rd_en && ptr_q == OFS_DMA_RD |=> ptr_q == OFS_DMA_RD)
		else $error("burst data pointer moved");
	a_read_launch: assert property (set_rd && !wr_pend_q && state_q == ST_IDLE
		|=> ##[0:2] ahb_o.htrans == HTRANS_NONSEQ && !ahb_o.hwrite)
		else $error("address byte 1 write did not launch read");
	a_read_suppress: assert property (wr_en && ptr_q == OFS_MADDR1 && !rd_pend_q
		&& maddr_q[0][1:0] == RD_SUPPRESS && ctl_q[1:0] == RD_SUPPRESS |=> !rd_pend_q)
		else $error("suppressed read was launched");
	a_read_store: assert property (done_rd && !wr_en |=> mdata_q == $past(ahb_i.hrdata))
		else $error("read word not stored");
	a_data_read_keep: assert property (rd_en && in_rng(ptr_q, OFS_MDATA0) |=> $stable(maddr_q))
		else $error("data read changed address");
	a_addr_plus_four: assert property (set_wr |=> maddr_q[1:0] == 16'($past(maddr_q[1:0]) + ADDR_STEP))
		else $error("address not stepped by four");
	a_upper_addr_keep: assert property (set_wr |=> maddr_q[3:2] == $past(maddr_q[3:2]))
		else $error("upper address changed");
	a_burst_loop: assert property (set_wr |=> ptr_q == OFS_MDATA0)
		else $error("pointer did not loop to data byte 0");
	a_dma_kick: assert property (start_dma && !dbg1_q[0] |=> dma_run_q && dleft_q != 15'h0)
		else $error("burst length write did not start dma");
	a_pend_shown: assert property (take_wr || take_rd |=> ahb_stat[0] [*2])
		else $error("pending flag missing");
	c_burst_write: cover property (set_wr ##[1:300] set_wr);
	c_single_read: cover property (set_rd ##[1:20] done_rd);
	c_dma_pop: cover property (pop_dma && !dempty);
	c_pkt_pop: cover property (pop_pkt);
endmodule // hrc_host_register_controller
`default_nettype wire

// >>> tb/hrc_spi_host.sv
// hrc_spi_host: serial master model standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module hrc_spi_host (
	output logic       sclk,
	output logic       ss_n,
	output logic       mosi,
	input  wire logic  miso,
	output logic [7:0] rx_byte
);
	event got;
	initial
	begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
		rx_byte = 8'h00;
	end
	// a read frame answers from its fourth byte on, so only those are handed on
	task automatic frame(input logic [7:0] b[$]);
		ss_n = 1'b0;
		foreach (b[i])
		begin
			for (int k = 7; k >= 0; k--)
			begin
				mosi = b[i][k];
				#80 sclk = 1'b1;
				rx_byte = {rx_byte[6:0], miso};
				#80 sclk = 1'b0;
			end
			if (!b[0][7] && i > 2)
				-> got;
		end
		#80 ss_n = 1'b1;
		mosi = ~mosi;
		if (b[0][7])
			repeat (2)
			begin
				#80 sclk = 1'b1;
				#80 sclk = 1'b0;
			end
		#400;
	endtask
endmodule // hrc_spi_host
`default_nettype wire

// >>> tb/hrc_host_register_controller_tb.sv
// hrc_host_register_controller_tb: self-checking bench for the host register controller
`timescale 1ns/10ps
`default_nettype none
module hrc_host_register_controller_tb;
	import hrc_pkg::*;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  sclk, ss_n, mosi, miso, miso_oe;
	logic [7:0]            rx_byte, gen_status, d[$], e[$];
	logic [3:0][7:0]       pkt_data;
	logic [3:0]            pkt_pop;
	hrc_ahb_out_type       ahb_o;
	hrc_ahb_in_type        ahb_i;
	logic [67:0]           ahb_q[$], cur;
	int                    miscompares = 0, n_compared = 0, pops = 0;
	always #5 clk = ~clk;
	hrc_host_register_controller hrc_host_register_controller_i (.clk, .rst_n, .sclk, .ss_n, .mosi, .miso,
		.miso_oe, .ahb_o, .ahb_i, .pkt_data, .pkt_pop, .gen_status);
	hrc_spi_host hrc_spi_host_i (.sclk, .ss_n, .mosi, .miso, .rx_byte);
	task automatic chk(input string what, input logic [67:0] x, input logic [67:0] s);
		n_compared++;
		if (x !== s)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, x, s);
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] b[$]);
		b.push_front({1'b1, a});
		hrc_spi_host_i.frame(b);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] x[$]);
		logic [7:0] b[$];
		b = {x, 8'h00, 8'h00};
		b.push_front({1'b0, a});
		e = {e, x};
		hrc_spi_host_i.frame(b);
	endtask
	// read words are derived from their address so any misrouted word shows
	task automatic exp_ahb(input logic w, input logic [31:0] a, input logic [31:0] x);
		ahb_q.push_back({w, HSIZE_WORD, a, x});
	endtask
	always @(posedge clk)
	begin
		if (pkt_pop[0] === 1'b1)
			pops++;
		#1 ahb_i.hready = 1'($urandom);
		if (ahb_o.htrans === HTRANS_NONSEQ)
			ahb_i.hrdata = ~ahb_o.haddr;
	end
	always @(hrc_spi_host_i.got)
	begin
		chk("serial byte", e.size() ? e.pop_front() : 8'hxx, rx_byte);
		chk("miso enable", 1'b1, miso_oe);
	end
	initial forever
	begin
		@(posedge clk);
		if (rst_n && ahb_o.htrans === HTRANS_NONSEQ && ahb_i.hready === 1'b1)
		begin
			cur = {ahb_o.hwrite, ahb_o.hsize, ahb_o.haddr, 32'h0};
			do @(posedge clk); while (ahb_i.hready !== 1'b1);
			if (cur[67])
				cur[31:0] = ahb_o.hwdata;
			chk("ahb transfer", ahb_q.size() ? ahb_q.pop_front() : '1, cur);
		end
	end
	initial
	begin
		#500us;
		miscompares++;
		print_verdict();
	end
	initial
	begin
		ahb_i = '0;
		cur = $urandom(32'h72c4);
		pkt_data = $urandom;
		gen_status = 8'($urandom);
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		d = {8'($urandom)};
		wr(OFS_SCRATCH, d);
		rd(OFS_SCRATCH, {d[0], gen_status});
		rd(OFS_PKT0, {pkt_data[0], pkt_data[0], pkt_data[0]});
		wr(OFS_PKT0, {8'h11});
		chk("fifo pops", 3, pops);
		wr(OFS_ACC_CTL, {8'h03});
		wr(OFS_MADDR0, {8'hff, 8'hff, 8'h12, 8'h34});
		d = {};
		repeat (8) d.push_back(8'($urandom));
		exp_ahb(1'b1, 32'h3412fffc, {d[3], d[2], d[1], d[0]});
		exp_ahb(1'b1, 32'h34120000, {d[7], d[6], d[5], d[4]});
		wr(OFS_MDATA0, d);
		wr(OFS_ACC_CTL, {8'h00});
		exp_ahb(1'b0, 32'h34120044, 32'h0);
		wr(OFS_MADDR0, {8'h47, 8'h00});
		rd(OFS_AHB_STAT, {8'h0a});
		rd(OFS_MDATA0, {8'hbb, 8'hff, 8'hed, 8'hcb});
		rd(OFS_MADDR0, {8'h47, 8'h00, 8'h12, 8'h34});
		wr(OFS_BLEN_LO, {8'h02});
		wr(OFS_BLEN_HI, {8'h00});
		exp_ahb(1'b0, 32'h34120008, 32'h0);
		exp_ahb(1'b0, 32'h3412000c, 32'h0);
		wr(OFS_DADDR0, {8'h0b, 8'h00, 8'h12, 8'h34, 8'h04, 8'h00});
		rd(OFS_DMA_STAT, {8'h00});
		rd(OFS_DMA_RD, {8'hf7, 8'hff, 8'hed, 8'hcb, 8'hf3, 8'hff, 8'hed, 8'hcb});
		#2us;
		chk("leftover", 0, ahb_q.size() + e.size());
		print_verdict();
	end
endmodule // hrc_host_register_controller_tb
`default_nettype wire
